// >>> verilog/shb_pkg.sv
// constants shared by the second half-band stage and its partner end
`default_nettype none
package shb_pkg;
  localparam int IN_W = 20;
  localparam int OUT_W = 24;
  localparam int COEF_W = 16;
  localparam int FINE_W = 14;
  localparam int ACC_W = 42;
  localparam int NSTORED = 32;
  localparam int NTAPS = 63;
  localparam logic [4:0] CENTER_TAP = 5'h1f;
  localparam logic [5:0] LAST_TAP = 6'h3e;
  // coefficient /65536, fine /1024, output 4 bits finer than input
  localparam int RND_SHIFT = 22;
  // channel control page offsets
  localparam logic [7:0] ADDR_GLOBAL_REAL = 8'h12;
  localparam logic [7:0] ADDR_GAIN_SYNC = 8'h16;
  localparam logic [7:0] ADDR_SIGN_CTL = 8'h18;
  localparam logic [7:0] ADDR_MODE = 8'h1a;
  localparam logic [7:0] ADDR_FINE = 8'h1c;
  localparam logic [7:0] ADDR_OVF_ROUTE = 8'h1d;
  localparam logic [7:0] ADDR_COEF_BASE = 8'h40;
  // field positions in the sign control word
  localparam int SPLIT_BIT = 4;
  localparam int REAL_HALF_BIT = 5;
  localparam int IMAG_HALF_BIT = 6;
  // field positions in the mode word
  localparam int ASYM_BIT = 0;
  localparam int REAL_DLY_BIT = 1;
  localparam int IMAG_DLY_BIT = 2;
  localparam logic [3:0] SIGN_C2R = 4'h6;
  localparam logic [3:0] CIC_MIN_NORMAL = 4'h8;
  localparam logic [3:0] CIC_MIN_SPLIT = 4'h4;
  localparam logic [13:0] FINE_RESET = 14'h0400;
  // partner end own registers
  localparam logic [7:0] ADDR_HOST_STATUS = 8'h80;
  localparam logic [7:0] ADDR_HOST_REAL = 8'h81;
  localparam logic [7:0] ADDR_HOST_IMAG = 8'h82;
  localparam logic [7:0] ADDR_HOST_CTRL = 8'h83;
  localparam int HOST_SPACE_BIT = 7;
endpackage : shb_pkg
`default_nettype wire

// >>> verilog/shb_link_if.sv
// link between the filter stage and the resampler input side
`timescale 1ns/1ps
`default_nettype none
interface shb_link_if;
  logic cfg_wr;
  logic [7:0] cfg_addr;
  logic [15:0] cfg_data;
  logic smp_valid;
  logic [23:0] smp_real;
  logic [23:0] smp_imag;
  logic smp_real_only;
  logic smp_ovf;
  modport device (
    input cfg_wr, cfg_addr, cfg_data,
    output smp_valid, smp_real, smp_imag, smp_real_only, smp_ovf
  );
  modport host (
    output cfg_wr, cfg_addr, cfg_data,
    input smp_valid, smp_real, smp_imag, smp_real_only, smp_ovf
  );
endinterface : shb_link_if
`default_nettype wire

// >>> verilog/shb_gain_sat.sv
// negation, fine gain, rounding and saturation for one path
`timescale 1ns/1ps
`default_nettype none
module shb_gain_sat (
  input wire logic signed [shb_pkg::ACC_W-1:0] acc_in,
  input wire logic neg_in,
  input wire logic [shb_pkg::FINE_W-1:0] fine_in,
  output logic [shb_pkg::OUT_W-1:0] sat_out,
  output logic ovf_out
);
  localparam int PW = shb_pkg::ACC_W + shb_pkg::FINE_W + 2;
  localparam int SW = PW - shb_pkg::RND_SHIFT;
  localparam logic signed [PW-1:0] HALF = PW'(1) <<< (shb_pkg::RND_SHIFT - 1);
  localparam logic signed [SW-1:0] MAXV = SW'((1 << (shb_pkg::OUT_W - 1)) - 1);
  localparam logic signed [SW-1:0] MINV = -SW'(1 << (shb_pkg::OUT_W - 1));
  wire logic signed [shb_pkg::ACC_W:0] signed_v;
  wire logic signed [PW-1:0] prod;
  wire logic signed [SW-1:0] rounded;
  wire logic hi;
  wire logic lo;
  assign signed_v = neg_in ? -(shb_pkg::ACC_W+1)'(acc_in) : (shb_pkg::ACC_W+1)'(acc_in);
  // zero fine gain clears the channel through the product
  assign prod = PW'(signed_v) * PW'($signed({1'b0, fine_in}));
  assign rounded = SW'((prod + HALF) >>> shb_pkg::RND_SHIFT);
  assign hi = rounded > MAXV;
  assign lo = rounded < MINV;
  // clamp matching the sign of the unclamped value
  assign sat_out = hi ? MAXV[shb_pkg::OUT_W-1:0] : (lo ? MINV[shb_pkg::OUT_W-1:0]
    : rounded[shb_pkg::OUT_W-1:0]);
  assign ovf_out = hi | lo;
endmodule : shb_gain_sat
`default_nettype wire

// >>> verilog/shb_fir_stage.sv
// second decimate-by-two filter stage, device end of the link
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module shb_fir_stage (
  input wire logic clk_in,
  input wire logic srst_in,
  shb_link_if.device link,
  input wire logic in_valid_in,
  input wire logic [shb_pkg::IN_W-1:0] in_real_in,
  input wire logic [shb_pkg::IN_W-1:0] in_imag_in,
  input wire logic gain_sync_in,
  output logic in_ready_out,
  output logic [3:0] cic_min_dec_out
);
  typedef enum logic [1:0] {SHB_IDLE, SHB_MAC, SHB_SCALE} shb_state_t;
  localparam int TW = shb_pkg::IN_W + 1;
  localparam int PRW = TW + shb_pkg::COEF_W;

  //////////////////////////////////////////////////////////////////////
  // configuration
  logic signed [shb_pkg::COEF_W-1:0] coef [0:shb_pkg::NSTORED-1];
  logic [6:0] sign_ctl;
  logic [2:0] mode;
  logic gain_sync_mode;
  logic global_real;
  logic ovf_route;
  logic [shb_pkg::FINE_W-1:0] fine_pend;
  logic [shb_pkg::FINE_W-1:0] fine_act;
  wire logic cfg_coef;
  wire logic c2r_mode;
  wire logic asym;

  assign cfg_coef = link.cfg_wr && link.cfg_addr[7:5] == shb_pkg::ADDR_COEF_BASE[7:5];
  assign asym = mode[shb_pkg::ASYM_BIT];
  // c2r is recognised from the delay and sign pattern software writes
  assign c2r_mode = mode[shb_pkg::REAL_DLY_BIT] && sign_ctl[3:0] == shb_pkg::SIGN_C2R;

  always_ff @(posedge clk_in)
  begin
    if (cfg_coef)
    begin
      coef[link.cfg_addr[4:0]] <= link.cfg_data;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      sign_ctl <= '0;
      mode <= '0;
      gain_sync_mode <= 1'b0;
      global_real <= 1'b0;
      ovf_route <= 1'b0;
      fine_pend <= shb_pkg::FINE_RESET;
    end
    else if (link.cfg_wr)
    begin
      case (link.cfg_addr)
        shb_pkg::ADDR_SIGN_CTL: sign_ctl <= link.cfg_data[6:0];
        shb_pkg::ADDR_MODE: mode <= link.cfg_data[2:0];
        shb_pkg::ADDR_GAIN_SYNC: gain_sync_mode <= link.cfg_data[0];
        shb_pkg::ADDR_GLOBAL_REAL: global_real <= link.cfg_data[0];
        shb_pkg::ADDR_OVF_ROUTE: ovf_route <= link.cfg_data[0];
        shb_pkg::ADDR_FINE: fine_pend <= link.cfg_data[shb_pkg::FINE_W-1:0];
        default: ;
      endcase
    end
  end

  // held gain keeps beam-forming channels changing together
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      fine_act <= shb_pkg::FINE_RESET;
    end
    else if (!gain_sync_mode || gain_sync_in)
    begin
      fine_act <= fine_pend;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      cic_min_dec_out <= shb_pkg::CIC_MIN_NORMAL;
    end
    else
    begin
      // split mode: imag input already carries the second real half
      cic_min_dec_out <= sign_ctl[shb_pkg::SPLIT_BIT] ? shb_pkg::CIC_MIN_SPLIT
        : shb_pkg::CIC_MIN_NORMAL;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // delay lines, index 0 newest
  logic signed [shb_pkg::IN_W-1:0] line_r [0:shb_pkg::NTAPS-1];
  logic signed [shb_pkg::IN_W-1:0] line_i [0:shb_pkg::NTAPS-1];
  logic [shb_pkg::IN_W-1:0] prev_r;
  logic [shb_pkg::IN_W-1:0] prev_i;
  logic phase;
  shb_state_t state;
  logic [4:0] tap;
  wire logic accept;
  wire logic start;
  wire logic [shb_pkg::IN_W-1:0] push_r;
  wire logic [shb_pkg::IN_W-1:0] push_i;

  assign accept = in_valid_in && in_ready_out;
  // decimate: compute on every second sample unless c2r
  assign start = accept && (phase || c2r_mode);
  // delayed path lags one sample, shifting its decimation phase
  assign push_r = mode[shb_pkg::REAL_DLY_BIT] ? prev_r : in_real_in;
  assign push_i = mode[shb_pkg::IMAG_DLY_BIT] ? prev_i : in_imag_in;

  always_ff @(posedge clk_in)
  begin
    if (accept)
    begin
      line_r[0] <= push_r;
      line_i[0] <= push_i;
      for (int n = 1; n < shb_pkg::NTAPS; n++)
      begin
        line_r[n] <= line_r[n-1];
        line_i[n] <= line_i[n-1];
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      prev_r <= '0;
      prev_i <= '0;
      phase <= 1'b0;
    end
    else if (accept)
    begin
      prev_r <= in_real_in;
      prev_i <= in_imag_in;
      phase <= ~phase;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // one stored coefficient per cycle; the mirror tap shares its product
  function automatic logic signed [TW-1:0] tap_term(
    input logic signed [shb_pkg::IN_W-1:0] near_x,
    input logic signed [shb_pkg::IN_W-1:0] far_x,
    input logic single
  );
    tap_term = single ? TW'(near_x) : TW'(near_x) + TW'(far_x);
  endfunction : tap_term

  wire logic [5:0] mirror;
  wire logic single;
  wire logic signed [PRW-1:0] prod_r;
  wire logic signed [PRW-1:0] prod_i;
  logic signed [shb_pkg::ACC_W-1:0] acc_r;
  logic signed [shb_pkg::ACC_W-1:0] acc_i;
  logic odd;

  assign mirror = shb_pkg::LAST_TAP - {1'b0, tap};
  assign single = asym || tap == shb_pkg::CENTER_TAP;
  assign prod_r = PRW'(tap_term(line_r[tap], line_r[mirror], single)) * PRW'(coef[tap]);
  assign prod_i = PRW'(tap_term(line_i[tap], line_i[mirror], single)) * PRW'(coef[tap]);

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      state <= SHB_IDLE;
      tap <= '0;
      acc_r <= '0;
      acc_i <= '0;
    end
    else
    begin
      case (state)
        SHB_IDLE:
        begin
          if (start)
          begin
            state <= SHB_MAC;
            tap <= '0;
            acc_r <= '0;
            acc_i <= '0;
          end
        end
        SHB_MAC:
        begin
          acc_r <= acc_r + shb_pkg::ACC_W'(prod_r);
          acc_i <= acc_i + shb_pkg::ACC_W'(prod_i);
          tap <= tap + 5'h01;
          if (tap == shb_pkg::CENTER_TAP)
          begin
            state <= SHB_SCALE;
          end
        end
        SHB_SCALE: state <= SHB_IDLE;
        default: state <= SHB_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // sign, gain, rounding and output
  wire logic [shb_pkg::OUT_W-1:0] res_r;
  wire logic [shb_pkg::OUT_W-1:0] res_i;
  wire logic ovf_r;
  wire logic ovf_i;
  wire logic [shb_pkg::OUT_W-1:0] half_r;
  wire logic [shb_pkg::OUT_W-1:0] half_i;

  shb_gain_sat u_gain_r (
    .acc_in(acc_r),
    .neg_in(odd ? sign_ctl[2] : sign_ctl[0]),
    .fine_in(fine_act),
    .sat_out(res_r),
    .ovf_out(ovf_r)
  );

  shb_gain_sat u_gain_i (
    .acc_in(acc_i),
    .neg_in(odd ? sign_ctl[3] : sign_ctl[1]),
    .fine_in(fine_act),
    .sat_out(res_i),
    .ovf_out(ovf_i)
  );

  // a half select passes only that half, the other reads zero
  assign half_r = sign_ctl[shb_pkg::IMAG_HALF_BIT] && !sign_ctl[shb_pkg::REAL_HALF_BIT]
    ? '0 : res_r;
  assign half_i = sign_ctl[shb_pkg::REAL_HALF_BIT] && !sign_ctl[shb_pkg::IMAG_HALF_BIT]
    ? '0 : res_i;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      odd <= 1'b0;
      link.smp_valid <= 1'b0;
      link.smp_real <= '0;
      link.smp_imag <= '0;
      link.smp_real_only <= 1'b0;
      link.smp_ovf <= 1'b0;
      in_ready_out <= 1'b0;
    end
    else
    begin
      in_ready_out <= state == SHB_IDLE && !start;
      link.smp_real_only <= global_real;
      link.smp_valid <= state == SHB_SCALE;
      link.smp_ovf <= state == SHB_SCALE && ovf_route && (ovf_r || ovf_i);
      if (state == SHB_SCALE)
      begin
        odd <= ~odd;
        // real-only moves the imag-half real samples to the real field
        link.smp_real <= global_real ? half_i : half_r;
        link.smp_imag <= global_real ? '0 : half_i;
      end
    end
  end
endmodule : shb_fir_stage
`default_nettype wire

// >>> verilog/shb_buf_host.sv
// resampler input side: command port, pair sum and sample capture
`timescale 1ns/1ps
`default_nettype none
module shb_buf_host (
  input wire logic clk_in,
  input wire logic srst_in,
  shb_link_if.host link,
  input wire logic [7:0] sw_addr_in,
  input wire logic [15:0] sw_wdata_in,
  input wire logic sw_wr_in,
  input wire logic sw_rd_in,
  input wire logic [23:0] peer_real_in,
  input wire logic [23:0] peer_imag_in,
  output logic [15:0] sw_rdata_out,
  output logic buf_valid_out,
  output logic [23:0] buf_real_out,
  output logic [23:0] buf_imag_out
);
  function automatic logic [23:0] sat_add(input logic [23:0] a, input logic [23:0] b);
    logic [24:0] s;
    s = {a[23], a} + {b[23], b};
    sat_add = s[24] == s[23] ? s[23:0] : {s[24], {23{~s[24]}}};
  endfunction : sat_add

  logic pair_sum;
  logic ovf_seen;
  logic [7:0] smp_count;
  wire logic host_space;
  wire logic [23:0] sum_r;
  wire logic [23:0] sum_i;

  assign host_space = sw_addr_in[shb_pkg::HOST_SPACE_BIT];
  // channel A outputs added into channel B when enabled
  assign sum_r = pair_sum ? sat_add(link.smp_real, peer_real_in) : link.smp_real;
  assign sum_i = pair_sum ? sat_add(link.smp_imag, peer_imag_in) : link.smp_imag;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      link.cfg_wr <= 1'b0;
      link.cfg_addr <= '0;
      link.cfg_data <= '0;
    end
    else
    begin
      // device settings, including sign patterns software chooses
      link.cfg_wr <= sw_wr_in && !host_space;
      link.cfg_addr <= sw_addr_in;
      link.cfg_data <= sw_wdata_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      pair_sum <= 1'b0;
      ovf_seen <= 1'b0;
      smp_count <= '0;
      buf_valid_out <= 1'b0;
      buf_real_out <= '0;
      buf_imag_out <= '0;
      sw_rdata_out <= '0;
    end
    else
    begin
      if (sw_wr_in && sw_addr_in == shb_pkg::ADDR_HOST_CTRL)
      begin
        pair_sum <= sw_wdata_in[0];
      end
      // a new overflow wins over a clear in the same cycle
      if (link.smp_ovf)
      begin
        ovf_seen <= 1'b1;
      end
      else if (sw_wr_in && sw_addr_in == shb_pkg::ADDR_HOST_STATUS && sw_wdata_in[0])
      begin
        ovf_seen <= 1'b0;
      end
      buf_valid_out <= link.smp_valid;
      if (link.smp_valid)
      begin
        smp_count <= smp_count + 8'h01;
        buf_real_out <= sum_r;
        buf_imag_out <= sum_i;
      end
      if (sw_rd_in)
      begin
        case (sw_addr_in)
          shb_pkg::ADDR_HOST_STATUS: sw_rdata_out <= {smp_count, 5'h00,
            link.smp_real_only, pair_sum, ovf_seen};
          shb_pkg::ADDR_HOST_REAL: sw_rdata_out <= buf_real_out[23:8];
          shb_pkg::ADDR_HOST_IMAG: sw_rdata_out <= buf_imag_out[23:8];
          shb_pkg::ADDR_HOST_CTRL: sw_rdata_out <= {15'h0000, pair_sum};
          default: sw_rdata_out <= 16'h0000;
        endcase
      end
      else
      begin
        sw_rdata_out <= 16'h0000;
      end
    end
  end
endmodule : shb_buf_host
`default_nettype wire

// >>> sim/shb_link_properties.sv
// concurrent checks on the link between the filter stage and the resampler side
`timescale 1ns/1ps
`default_nettype none
module shb_link_props (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [15:0] cfg_data,
  input wire logic smp_valid,
  input wire logic [23:0] smp_real,
  input wire logic [23:0] smp_imag,
  input wire logic smp_real_only,
  input wire logic smp_ovf
);
  ////////////////////////////////////////////////////////////////////////////////
  logic route_q;
  logic sync_q;
  logic fine_zero_q;
  wire wr_real = cfg_wr && cfg_addr == shb_pkg::ADDR_GLOBAL_REAL;
  wire wr_route = cfg_wr && cfg_addr == shb_pkg::ADDR_OVF_ROUTE;
  wire wr_sync = cfg_wr && cfg_addr == shb_pkg::ADDR_GAIN_SYNC;
  wire wr_fine = cfg_wr && cfg_addr == shb_pkg::ADDR_FINE;
  // a fine write in sync mode leaves the live gain unknown here, so stop checking
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      route_q <= 1'b0;
      sync_q <= 1'b0;
      fine_zero_q <= 1'b0;
    end
    else
    begin
      if (wr_route)
        route_q <= cfg_data[0];
      if (wr_sync)
        sync_q <= cfg_data[0];
      if (wr_fine)
        fine_zero_q <= !sync_q && cfg_data[13:0] == 14'h0000;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  sequence s_gap8;
    !smp_valid [*8];
  endsequence
  sequence s_quiet3;
    !wr_real [*3];
  endsequence
  property p_spacing;
    smp_valid |=> s_gap8;
  endproperty
  property p_ovf_with_valid;
    smp_ovf |-> smp_valid;
  endproperty
  property p_ovf_routed;
    smp_ovf |-> route_q;
  endproperty
  property p_clamp_value;
    smp_ovf |-> smp_real == 24'h7fffff || smp_real == 24'h800000
      || smp_imag == 24'h7fffff || smp_imag == 24'h800000;
  endproperty
  property p_fine_zero;
    smp_valid && fine_zero_q |-> smp_real == 24'h000000 && smp_imag == 24'h000000;
  endproperty
  property p_real_follows;
    wr_real |-> ##3 smp_real_only == $past(cfg_data[0], 3);
  endproperty
  property p_real_stable;
    s_quiet3 |=> $stable(smp_real_only);
  endproperty
  property p_real_imag_zero;
    smp_valid && smp_real_only |-> smp_imag == 24'h000000;
  endproperty
  a_spacing: assert property (p_spacing) else $error("sample strobes too close");
  a_ovf_with_valid: assert property (p_ovf_with_valid) else $error("overflow without sample");
  a_ovf_routed: assert property (p_ovf_routed) else $error("overflow while unrouted");
  a_clamp_value: assert property (p_clamp_value) else $error("overflow word not clamped");
  a_fine_zero: assert property (p_fine_zero) else $error("zero gain word not zero");
  a_real_follows: assert property (p_real_follows) else $error("real flag not updated");
  a_real_stable: assert property (p_real_stable) else $error("real flag moved unasked");
  a_real_imag_zero: assert property (p_real_imag_zero) else $error("imag word in real mode");
endmodule : shb_link_props
`default_nettype wire

// >>> sim/second_halfband_fir_stage_tb.sv
// self-checking bench joining the filter stage and the resampler side
`timescale 1ns/1ps
`default_nettype none
module second_halfband_fir_stage_tb;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic in_valid = 1'b0;
  logic [19:0] in_re = 20'h00000;
  logic [19:0] in_im = 20'h00000;
  logic gain_sync = 1'b0;
  logic [7:0] sw_addr = 8'h00;
  logic [15:0] sw_wdata = 16'h0000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [23:0] peer_re = 24'h000010;
  logic [23:0] peer_im = 24'h000020;
  logic in_ready;
  logic [3:0] cic_min;
  logic [15:0] sw_rdata;
  logic buf_valid;
  logic [23:0] buf_real;
  logic [23:0] buf_imag;
  logic [23:0] last_re;
  logic [23:0] prev_re;
  logic [23:0] last_im;
  logic [23:0] buf_re;
  logic [23:0] buf_im;
  logic last_ovf;
  logic [15:0] rd;
  int n_out = 0;
  int n_fail = 0;
  int comparisons = 0;
  shb_link_if link_i ();
  shb_fir_stage u_shb_fir_stage (.clk_in(clk_in), .srst_in(srst_in), .link(link_i),
    .in_valid_in(in_valid), .in_real_in(in_re), .in_imag_in(in_im), .gain_sync_in(gain_sync),
    .in_ready_out(in_ready), .cic_min_dec_out(cic_min));
  shb_buf_host u_shb_buf_host (.clk_in(clk_in), .srst_in(srst_in), .link(link_i),
    .sw_addr_in(sw_addr), .sw_wdata_in(sw_wdata), .sw_wr_in(sw_wr), .sw_rd_in(sw_rd),
    .peer_real_in(peer_re), .peer_imag_in(peer_im), .sw_rdata_out(sw_rdata),
    .buf_valid_out(buf_valid), .buf_real_out(buf_real), .buf_imag_out(buf_imag));
  shb_link_props u_shb_link_props (.clk_in(clk_in), .srst_in(srst_in),
    .cfg_wr(link_i.cfg_wr), .cfg_addr(link_i.cfg_addr), .cfg_data(link_i.cfg_data),
    .smp_valid(link_i.smp_valid), .smp_real(link_i.smp_real), .smp_imag(link_i.smp_imag),
    .smp_real_only(link_i.smp_real_only), .smp_ovf(link_i.smp_ovf));
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #2 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    if (link_i.smp_valid === 1'b1)
    begin
      prev_re <= last_re;
      last_re <= link_i.smp_real;
      last_im <= link_i.smp_imag;
      last_ovf <= link_i.smp_ovf;
      n_out <= n_out + 1;
    end
    if (buf_valid === 1'b1)
    begin
      buf_re <= buf_real;
      buf_im <= buf_imag;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task automatic sw_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk_in);
    sw_wr <= 1'b0;
  endtask : sw_write
  task automatic sw_read(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_in);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk_in);
    sw_rd <= 1'b0;
    @(negedge clk_in);
    d = sw_rdata;
  endtask : sw_read
  // even counts keep the decimation phase aligned; the tail drains the pipeline
  task automatic feed(input logic [19:0] x, input int n);
    int w;
    @(posedge clk_in);
    in_valid <= 1'b1;
    in_re <= x;
    in_im <= x;
    for (int i = 0; i < n; i++)
    begin
      w = 0;
      @(negedge clk_in);
      while (in_ready !== 1'b1 && w < 100)
      begin
        w++;
        @(negedge clk_in);
      end
      if (w == 100)
        n_fail++;
      @(posedge clk_in);
    end
    in_valid <= 1'b0;
    repeat (40) @(posedge clk_in);
  endtask : feed
  ////////////////////////////////////////////////////////////////////////////////
  // only h0 set: mirrored pair gives twice, asymmetric gives once
  task automatic t_taps();
    for (int k = 0; k < 32; k++)
      sw_write(shb_pkg::ADDR_COEF_BASE + 8'(k), (k == 0) ? 16'h4000 : 16'h0000);
    feed(20'h003e8, 66);
    check(last_re, 24'h001f40);
    check(last_im, 24'h001f40);
    sw_write(shb_pkg::ADDR_MODE, 16'(1 << shb_pkg::ASYM_BIT));
    feed(20'h003e8, 4);
    check(last_re, 24'h000fa0);
    // h1 alone weighs the second newest: only the delayed path still holds an old sample
    sw_write(shb_pkg::ADDR_COEF_BASE, 16'h0000);
    sw_write(shb_pkg::ADDR_COEF_BASE + 8'h01, 16'h4000);
    sw_write(shb_pkg::ADDR_MODE, 16'(1 << shb_pkg::ASYM_BIT) | 16'(1 << shb_pkg::IMAG_DLY_BIT));
    feed(20'h00000, 2);
    check(last_re, 24'h000000);
    check(last_im, 24'h000fa0);
    sw_write(shb_pkg::ADDR_COEF_BASE + 8'h01, 16'h0000);
    sw_write(shb_pkg::ADDR_COEF_BASE, 16'h4000);
    sw_write(shb_pkg::ADDR_MODE, 16'h0000);
  endtask : t_taps
  task automatic t_sign();
    sw_write(shb_pkg::ADDR_SIGN_CTL, 16'h000f);
    feed(20'h003e8, 4);
    check(last_re, 24'hffe0c0);
    check(last_im, 24'hffe0c0);
    sw_write(shb_pkg::ADDR_SIGN_CTL, 16'h0001);
    feed(20'h003e8, 4);
    check(n_out[0] ? last_re : prev_re, 24'hffe0c0);
    check(n_out[0] ? prev_re : last_re, 24'h001f40);
    sw_write(shb_pkg::ADDR_SIGN_CTL, 16'h0000);
  endtask : t_sign
  task automatic t_gain();
    sw_write(shb_pkg::ADDR_FINE, 16'h0000);
    feed(20'h003e8, 4);
    check(last_re, 24'h000000);
    sw_write(shb_pkg::ADDR_FINE, 16'h0800);
    feed(20'h003e8, 4);
    check(last_re, 24'h003e80);
    sw_write(shb_pkg::ADDR_FINE, 16'h0400);
    sw_write(shb_pkg::ADDR_GAIN_SYNC, 16'h0001);
    sw_write(shb_pkg::ADDR_FINE, 16'h0800);
    feed(20'h003e8, 4);
    check(last_re, 24'h001f40);
    @(posedge clk_in);
    gain_sync <= 1'b1;
    @(posedge clk_in);
    gain_sync <= 1'b0;
    feed(20'h003e8, 4);
    check(last_re, 24'h003e80);
    sw_write(shb_pkg::ADDR_GAIN_SYNC, 16'h0000);
  endtask : t_gain
  task automatic t_clamp();
    sw_write(shb_pkg::ADDR_OVF_ROUTE, 16'h0001);
    sw_write(shb_pkg::ADDR_FINE, 16'h3fff);
    feed(20'h7ffff, 66);
    check(last_re, 24'h7fffff);
    check(24'(last_ovf), 24'h000001);
    feed(20'h80000, 66);
    check(last_im, 24'h800000);
    sw_write(shb_pkg::ADDR_OVF_ROUTE, 16'h0000);
    feed(20'h80000, 4);
    check(24'(last_ovf), 24'h000000);
    sw_write(shb_pkg::ADDR_FINE, 16'h0400);
    feed(20'h003e8, 66);
  endtask : t_clamp
  task automatic t_real_split();
    sw_write(shb_pkg::ADDR_GLOBAL_REAL, 16'h0001);
    feed(20'h003e8, 4);
    check(24'(link_i.smp_real_only), 24'h000001);
    check(last_im, 24'h000000);
    check(last_re, 24'h001f40);
    sw_write(shb_pkg::ADDR_GLOBAL_REAL, 16'h0000);
    sw_write(shb_pkg::ADDR_SIGN_CTL, 16'(1 << shb_pkg::SPLIT_BIT));
    repeat (3) @(posedge clk_in);
    check(24'(cic_min), 24'(shb_pkg::CIC_MIN_SPLIT));
    sw_write(shb_pkg::ADDR_SIGN_CTL, 16'h0000);
    repeat (3) @(posedge clk_in);
    check(24'(cic_min), 24'(shb_pkg::CIC_MIN_NORMAL));
  endtask : t_real_split
  task automatic t_pair();
    feed(20'h003e8, 4);
    check(buf_re, 24'h001f40);
    sw_read(shb_pkg::ADDR_HOST_REAL, rd);
    check(24'(rd), 24'h00001f);
    sw_read(8'h90, rd);
    check(24'(rd), 24'h000000);
    sw_read(shb_pkg::ADDR_SIGN_CTL, rd);
    check(24'(rd), 24'h000000);
    sw_write(shb_pkg::ADDR_HOST_CTRL, 16'h0001);
    feed(20'h003e8, 4);
    check(buf_re, 24'h001f50);
    check(buf_im, 24'h001f60);
    sw_read(shb_pkg::ADDR_HOST_STATUS, rd);
    check(24'(rd[1]), 24'h000001);
    // overflow from the clamp test stays latched until software clears it
    check(24'(rd[0]), 24'h000001);
    sw_write(shb_pkg::ADDR_HOST_STATUS, 16'h0001);
    sw_read(shb_pkg::ADDR_HOST_STATUS, rd);
    check(24'(rd[0]), 24'h000000);
  endtask : t_pair
  // every taken sample yields a word once decimation is off
  task automatic t_c2r();
    int n0;
    sw_write(shb_pkg::ADDR_MODE, 16'(1 << shb_pkg::REAL_DLY_BIT));
    sw_write(shb_pkg::ADDR_SIGN_CTL, 16'(1 << shb_pkg::IMAG_HALF_BIT) | 16'(shb_pkg::SIGN_C2R));
    n0 = n_out;
    feed(20'h003e8, 8);
    check(24'(n_out - n0), 24'h000008);
    check(last_re, 24'h000000);
  endtask : t_c2r
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge clk_in);
    srst_in <= 1'b0;
    @(negedge clk_in);
    check(24'(cic_min), 24'(shb_pkg::CIC_MIN_NORMAL));
    t_taps();
    t_sign();
    t_gain();
    t_clamp();
    t_real_split();
    t_pair();
    t_c2r();
    close_out();
  end
  // about four times the expected run length
  initial
  begin
    #100000;
    n_fail++;
    close_out();
  end
endmodule : second_halfband_fir_stage_tb
`default_nettype wire
